/* File: design/rtd_reset_trigger_dispatch.sv */
`timescale 1ns/1ps
module rtd_reset_trigger_dispatch
    import rtd_pkg::*;
#(
    parameter logic [TMR_W-1:0] TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter logic [TMR_W-1:0] OVERRIDE_CYCLES = OVERRIDE_CYC,
    parameter logic [TMR_W-1:0] PWRCYC_CYCLES = PWRCYC_CYC
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cpuShutdown,
    input wire logic wholePlatformSel,
    input wire logic fullResetBit,
    input wire logic mcHostRstNoPc,
    input wire logic mcHostRstPc,
    input wire logic mcHostRstPwrDown,
    input wire logic mcPwrBtnOverride,
    input wire logic mcWatchdog,
    input wire logic mcUncorrErr,
    input wire logic mcGlobalRst,
    input wire logic pmWatchdog,
    input wire logic pwrBtnPressed,
    input wire logic processorPowerGood,
    input wire logic resetAck,
    input wire logic [1:0] sleepState,
    input wire logic wakeEvent,
    input wire logic deepSleepEn,
    input wire logic deepSleepCondOk,
    output logic resetWarn,
    output logic platformResetN,
    output logic powerOff,
    output logic globalResetReq,
    output logic deepSleepState,
    output logic requestDropped,
    output logic entryTimeout,
    output logic busy,
    output logic [1:0] outcome
);

    typedef struct packed {
        rtd_state_t st;
        rtd_outcome_t res;
        logic pwrDown;
        logic ovrSeen;
        logic warn;
        logic platRstN;
        logic pwrOff;
        logic glob;
        logic deep;
        logic drop;
        logic tmo;
    } rtd_dsp_t;

    rtd_dsp_t q;
    rtd_dsp_t d;

    logic tmrClr;
    logic tmrEn;
    logic [TMR_W-1:0] tmrLimit;
    logic tmrDone;
    logic ovrDone;
    logic ovrFire;
    logic inSleep;
    logic reqS5;
    logic reqGlobal;
    logic reqHostPc;
    logic reqHostNoPc;

    rtd_timer u_seq_timer (
        .clk(clk),
        .rst_b(rst_b),
        .clr(tmrClr),
        .en(tmrEn),
        .limit(tmrLimit),
        .done(tmrDone)
    );

    rtd_timer u_ovr_timer (
        .clk(clk),
        .rst_b(rst_b),
        .clr(!pwrBtnPressed),
        .en(pwrBtnPressed),
        .limit(OVERRIDE_CYCLES),
        .done(ovrDone)
    );

    assign ovrFire = ovrDone && !q.ovrSeen;
    assign inSleep = (sleepState != SLP_S0);

    // trigger classification
    assign reqS5 = ovrFire || mcPwrBtnOverride || mcWatchdog || mcUncorrErr
        || pmWatchdog;
    assign reqGlobal = mcGlobalRst || (cpuShutdown && wholePlatformSel);
    assign reqHostPc = mcHostRstPc || mcHostRstPwrDown
        || (cpuShutdown && !wholePlatformSel && fullResetBit);
    assign reqHostNoPc = mcHostRstNoPc
        || (cpuShutdown && !wholePlatformSel && !fullResetBit);

    always_comb begin
        d = q;
        d.ovrSeen = ovrDone;
        d.drop = 1'b0;
        d.tmo = 1'b0;
        tmrEn = 1'b1;
        tmrLimit = TIMEOUT_CYCLES;
        case (q.st)
            ST_IDLE: begin
                tmrEn = 1'b0;
                if (reqS5) begin
                    d.st = ST_S5;
                    d.res = OUT_S5;
                end else if (reqGlobal) begin
                    d.st = ST_ASSERT;
                    d.res = OUT_GLOBAL;
                end else if (reqHostPc) begin
                    d.res = OUT_HOST_PC;
                    d.pwrDown = mcHostRstPwrDown;
                    d.st = inSleep ? ST_ASSERT : ST_WARN;
                end else if (reqHostNoPc) begin
                    if (inSleep) begin
                        d.drop = 1'b1;
                    end else begin
                        d.st = ST_WARN;
                        d.res = OUT_HOST_NOPC;
                        d.pwrDown = 1'b0;
                    end
                end
            end
            ST_WARN: begin
                tmrLimit = TIMEOUT_CYCLES;
                if (reqGlobal) begin
                    d.st = ST_ASSERT;
                    d.res = OUT_GLOBAL;
                end else if (resetAck) begin
                    d.st = ST_ASSERT;
                end else if (tmrDone) begin
                    d.st = ST_ASSERT;
                    d.res = OUT_GLOBAL;
                    d.tmo = 1'b1;
                end
            end
            ST_ASSERT: begin
                tmrLimit = RSTHOLD_CYC;
                if (reqGlobal && (q.res != OUT_GLOBAL)) begin
                    d.res = OUT_GLOBAL;
                end
                if (tmrDone) begin
                    d.st = (d.res == OUT_HOST_NOPC) ? ST_EXIT : ST_PWROFF;
                end
            end
            ST_PWROFF: begin
                tmrLimit = PWRCYC_CYCLES;
                if (tmrDone) begin
                    d.st = (q.pwrDown && (q.res != OUT_GLOBAL)) ? ST_WAKE : ST_EXIT;
                end
            end
            ST_WAKE: begin
                tmrEn = 1'b0;
                if (reqGlobal) begin
                    d.st = ST_ASSERT;
                    d.res = OUT_GLOBAL;
                end else if (wakeEvent) begin
                    d.st = ST_EXIT;
                end
            end
            ST_EXIT: begin
                tmrLimit = TIMEOUT_CYCLES;
                if (processorPowerGood) begin
                    d.st = ST_IDLE;
                    d.pwrDown = 1'b0;
                end else if (tmrDone) begin
                    d.st = ST_ASSERT;
                    d.res = OUT_GLOBAL;
                    d.tmo = 1'b1;
                end
            end
            ST_S5: begin
                tmrEn = 1'b0;
                if (wakeEvent) begin
                    d.st = ST_EXIT;
                end else if (deepSleepEn && deepSleepCondOk) begin
                    d.st = ST_DEEP;
                end
            end
            ST_DEEP: begin
                tmrEn = 1'b0;
                if (wakeEvent) begin
                    d.st = ST_EXIT;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        // outputs follow the next state so they register with it
        d.warn = (d.st == ST_WARN);
        d.platRstN = (d.st == ST_IDLE) || (d.st == ST_WARN) || (d.st == ST_EXIT);
        d.pwrOff = (d.st == ST_PWROFF) || (d.st == ST_WAKE) || (d.st == ST_S5)
            || (d.st == ST_DEEP);
        d.glob = (d.res == OUT_GLOBAL) && ((d.st == ST_ASSERT) || (d.st == ST_PWROFF));
        d.deep = (d.st == ST_DEEP);
        tmrClr = (d.st != q.st);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q.st <= ST_IDLE;
            q.res <= OUT_HOST_NOPC;
            q.pwrDown <= 1'b0;
            q.ovrSeen <= 1'b0;
            q.warn <= 1'b0;
            q.platRstN <= 1'b1;
            q.pwrOff <= 1'b0;
            q.glob <= 1'b0;
            q.deep <= 1'b0;
            q.drop <= 1'b0;
            q.tmo <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign resetWarn = q.warn;
    assign platformResetN = q.platRstN;
    assign powerOff = q.pwrOff;
    assign globalResetReq = q.glob;
    assign deepSleepState = q.deep;
    assign requestDropped = q.drop;
    assign entryTimeout = q.tmo;
    assign busy = (q.st != ST_IDLE);
    assign outcome = q.res;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_s5_reset;
        (q.st == ST_IDLE) && ovrFire |=> (q.st == ST_S5) && !platformResetN && powerOff;
    endproperty
    a_s5_reset: assert property (p_s5_reset) else $error("override did not reach S5");

    property p_shut_global;
        (q.st == ST_IDLE) && !reqS5 && cpuShutdown && wholePlatformSel
            |=> (q.st == ST_ASSERT) && (outcome == OUT_GLOBAL) && !resetWarn;
    endproperty
    a_shut_global: assert property (p_shut_global) else $error("shutdown not global");

    property p_shut_host;
        (q.st == ST_IDLE) && !reqS5 && !mcGlobalRst && cpuShutdown && !wholePlatformSel
            && fullResetBit && !inSleep |=> (q.st == ST_WARN) && (outcome == OUT_HOST_PC);
    endproperty
    a_shut_host: assert property (p_shut_host) else $error("shutdown host type wrong");

    property p_mc_s5;
        (q.st == ST_IDLE) && (mcWatchdog || mcUncorrErr || pmWatchdog)
            |=> (q.st == ST_S5) ##1 (!globalResetReq && !resetWarn);
    endproperty
    a_mc_s5: assert property (p_mc_s5) else $error("watchdog not to S5");

    property p_drop;
        (q.st == ST_IDLE) && reqHostNoPc && !reqHostPc && !reqGlobal && !reqS5 && inSleep
            |=> (q.st == ST_IDLE) && requestDropped;
    endproperty
    a_drop: assert property (p_drop) else $error("sleep request not dropped");

    property p_global_nowarn;
        (outcome == OUT_GLOBAL) |-> !resetWarn;
    endproperty
    a_global_nowarn: assert property (p_global_nowarn) else $error("warn during global");

    property p_ack_tmo;
        (q.st == ST_WARN) && tmrDone && !resetAck && !reqGlobal
            |=> (q.st == ST_ASSERT) && (outcome == OUT_GLOBAL) && entryTimeout
            ##1 globalResetReq;
    endproperty
    a_ack_tmo: assert property (p_ack_tmo) else $error("no escalation on timeout");

    property p_ack;
        (q.st == ST_WARN) && resetAck && !reqGlobal
            |=> !platformResetN && !resetWarn && $stable(outcome);
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not assert reset");

    property p_deep;
        (q.st == ST_S5) && !wakeEvent && deepSleepEn && deepSleepCondOk
            |=> deepSleepState && powerOff;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep not entered");

    property p_pgood;
        (q.st == ST_EXIT) && tmrDone && !processorPowerGood
            |=> (q.st == ST_ASSERT) && (outcome == OUT_GLOBAL);
    endproperty
    a_pgood: assert property (p_pgood) else $error("power-good stuck not global");

    // while a sequence runs only a global cause or a timeout may rewrite the outcome
    property p_one_outcome;
        busy && !reqGlobal && !tmrDone |=> $stable(outcome);
    endproperty
    a_one_outcome: assert property (p_one_outcome) else $error("outcome changed");

endmodule

/* File: design/rtd_pkg.sv */
package rtd_pkg;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_WARN   = 4'b0001,
        ST_ASSERT = 4'b0010,
        ST_PWROFF = 4'b0011,
        ST_WAKE   = 4'b0100,
        ST_EXIT   = 4'b0101,
        ST_S5     = 4'b0110,
        ST_DEEP   = 4'b0111
    } rtd_state_t;

    typedef enum logic [1:0] {
        OUT_HOST_NOPC = 2'b00,
        OUT_HOST_PC   = 2'b01,
        OUT_GLOBAL    = 2'b10,
        OUT_S5        = 2'b11
    } rtd_outcome_t;

    typedef enum logic [1:0] {
        SLP_S0 = 2'b00,
        SLP_S3 = 2'b01,
        SLP_S4 = 2'b10,
        SLP_S5 = 2'b11
    } rtd_sleep_t;

    localparam int CLK_HZ = 125000000;
    localparam int TMR_W = 32;

    // acknowledge / entry / power-good timeout
    localparam int TIMEOUT_SEC = 4;
    localparam logic [TMR_W-1:0] TIMEOUT_CYC = TMR_W'(TIMEOUT_SEC * CLK_HZ);

    // power-button override hold time
    localparam int OVERRIDE_SEC = 4;
    localparam logic [TMR_W-1:0] OVERRIDE_CYC = TMR_W'(OVERRIDE_SEC * CLK_HZ);

    // power-cycle off period, plain default
    localparam int PWRCYC_MS = 1;
    localparam logic [TMR_W-1:0] PWRCYC_CYC = TMR_W'(PWRCYC_MS * (CLK_HZ / 1000));

    // platform reset assertion hold, plain default
    localparam int RSTHOLD_US = 1;
    localparam logic [TMR_W-1:0] RSTHOLD_CYC = TMR_W'(RSTHOLD_US * (CLK_HZ / 1000000));

    localparam logic [TMR_W-1:0] TMR_RST = 32'h0000_0000;

endpackage

/* File: design/rtd_timer.sv */
`timescale 1ns/1ps
module rtd_timer
    import rtd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic en,
    input wire logic [TMR_W-1:0] limit,
    output logic done
);

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } rtd_tmr_t;

    rtd_tmr_t q;
    rtd_tmr_t d;

    always_comb begin
        d = q;
        if (clr) begin
            d.cnt = TMR_RST;
        end else if (en && (q.cnt != limit)) begin
            d.cnt = q.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q.cnt <= TMR_RST;
        end else begin
            q <= d;
        end
    end

    // saturates at limit, stays set until cleared
    assign done = (q.cnt == limit);

endmodule

/* File: test/rtd_cpu_model.sv */
`timescale 1ns/1ps
module rtd_cpu_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic resetWarn,
    input wire logic platformResetN,
    input wire logic ackOn,
    input wire logic pgStuck,
    input wire logic [3:0] ackDly,
    output logic resetAck,
    output logic processorPowerGood
);
    logic [3:0] cnt;
    logic [2:0] pgCnt;
    // acknowledge once memory is safe, after a chosen delay
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            resetAck <= 1'b0;
        end else begin
            resetAck <= resetWarn && ackOn && (cnt == ackDly);
            cnt <= resetWarn ? cnt + 4'h1 : 4'h0;
        end
    end
    // power good drops under platform reset, returns a few cycles later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pgCnt <= 3'h5;
            processorPowerGood <= 1'b1;
        end else if (!platformResetN) begin
            pgCnt <= 3'h0;
            processorPowerGood <= 1'b0;
        end else if (pgCnt < 3'h5) begin
            pgCnt <= pgCnt + 3'h1;
        end else begin
            processorPowerGood <= !pgStuck;
        end
    end
endmodule

/* File: test/test_reset_trigger_dispatch.sv */
`timescale 1ns/1ps
module test_reset_trigger_dispatch;
    import rtd_pkg::*;
    logic clk, rst_b, sel, fbit, pwrBtn, wake, dsEn, dsOk, ackOn, pgStuck;
    logic [8:0] trig;
    logic [1:0] sleep;
    logic [3:0] ackDly;
    logic resetAck, pg, resetWarn, platformResetN, powerOff, globalResetReq;
    logic deepSleepState, requestDropped, entryTimeout, busy;
    logic [1:0] outcome;
    logic sawTo, sawGl, sawPr, bad;
    int errors = 0;
    int check_count = 0;
    int seed = 96;

    rtd_reset_trigger_dispatch #(.TIMEOUT_CYCLES(32'h32), .OVERRIDE_CYCLES(32'h14),
        .PWRCYC_CYCLES(32'ha)) i_dut (.clk(clk), .rst_b(rst_b), .cpuShutdown(trig[0]),
        .wholePlatformSel(sel), .fullResetBit(fbit), .mcHostRstNoPc(trig[1]),
        .mcHostRstPc(trig[2]), .mcHostRstPwrDown(trig[3]), .mcPwrBtnOverride(trig[4]),
        .mcWatchdog(trig[5]), .mcUncorrErr(trig[6]), .mcGlobalRst(trig[7]),
        .pmWatchdog(trig[8]), .pwrBtnPressed(pwrBtn), .processorPowerGood(pg),
        .resetAck(resetAck), .sleepState(sleep), .wakeEvent(wake), .deepSleepEn(dsEn),
        .deepSleepCondOk(dsOk), .resetWarn(resetWarn), .platformResetN(platformResetN),
        .powerOff(powerOff), .globalResetReq(globalResetReq),
        .deepSleepState(deepSleepState), .requestDropped(requestDropped),
        .entryTimeout(entryTimeout), .busy(busy), .outcome(outcome));
    rtd_cpu_model i_cpu (.clk(clk), .rst_b(rst_b), .resetWarn(resetWarn),
        .platformResetN(platformResetN), .ackOn(ackOn), .pgStuck(pgStuck),
        .ackDly(ackDly), .resetAck(resetAck), .processorPowerGood(pg));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] exp_out(input int k, input logic s, input logic b);
        case (k)
            0: exp_out = s ? OUT_GLOBAL : (b ? OUT_HOST_PC : OUT_HOST_NOPC);
            1: exp_out = OUT_HOST_NOPC;
            2, 3: exp_out = OUT_HOST_PC;
            7: exp_out = OUT_GLOBAL;
            default: exp_out = OUT_S5;
        endcase
    endfunction

    // run to idle, waking the host late; record what was seen
    task automatic drain(input logic waitExp);
        sawTo = 0;
        sawGl = 0;
        sawPr = 0;
        bad = 0;
        for (int n = 0; n < 800 && busy !== 1'b0; n++) begin
            @(posedge clk);
            #1;
            wake = 1'b0;
            if (entryTimeout !== 1'b0) sawTo = 1;
            if (entryTimeout === 1'b1) pgStuck = 1'b0;
            if (globalResetReq !== 1'b0) sawGl = 1;
            if (platformResetN === 1'b0) sawPr = 1;
            if (resetWarn !== 1'b0 && platformResetN !== 1'b1) bad = 1;
            if (n == 400) begin
                chk_flag(busy, waitExp);
                wake = 1'b1;
            end
        end
        chk_flag(busy, 1'b0);
    endtask

    task automatic seq(input int k);
        logic [1:0] e;
        logic host, warn, to;
        e = exp_out(k, sel, fbit);
        host = (e == OUT_HOST_NOPC) || (e == OUT_HOST_PC);
        warn = host && (sleep == SLP_S0);
        to = (warn && !ackOn) || pgStuck;
        @(posedge clk);
        #1;
        if (k == 9) begin
            pwrBtn = 1'b1;
            for (int n = 0; n < 30 && busy !== 1'b1; n++) @(posedge clk) #1;
            pwrBtn = 1'b0;
        end else begin
            trig[k] = 1'b1;
            @(posedge clk);
            #1;
            trig = '0;
        end
        if (e == OUT_HOST_NOPC && sleep != SLP_S0) begin
            chk_flag(requestDropped, 1'b1);
            chk_flag(busy, 1'b0);
            return;
        end
        chk_out(outcome, e);
        chk_flag(resetWarn, warn);
        chk_flag(powerOff, e == OUT_S5);
        @(posedge clk);
        #1;
        if (e == OUT_S5) chk_flag(deepSleepState, dsEn & dsOk);
        drain((e == OUT_S5) || (k == 3 && !to));
        chk_flag(sawTo, to);
        chk_flag(sawGl, e == OUT_GLOBAL || to);
        chk_flag(sawPr, 1'b1);
        chk_flag(bad, 1'b0);
    endtask

    initial begin
        rst_b = 1'b0;
        {sel, fbit, pwrBtn, wake, dsEn, dsOk, pgStuck} = '0;
        trig = '0;
        sleep = SLP_S0;
        ackOn = 1'b1;
        ackDly = 4'h3;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        for (int m = 0; m < 3; m++) begin
            {sel, fbit} = 2'(m);
            seq(0);
        end
        for (int k = 1; k < 10; k++) seq(k);
        {dsEn, dsOk} = 2'h3;
        seq(5);
        for (int s = 1; s < 4; s++) begin
            sleep = 2'(s);
            seq(1);
            seq(s + 1);
        end
        sleep = SLP_S0;
        ackOn = 1'b0;
        seq(2);
        ackOn = 1'b1;
        pgStuck = 1'b1;
        seq(7);
        ackOn = 1'b0;
        @(posedge clk);
        #1;
        trig[1] = 1'b1;
        @(posedge clk);
        #1;
        trig[1] = 1'b0;
        trig[5] = 1'b1;
        @(posedge clk);
        #1;
        trig[5] = 1'b0;
        chk_out(outcome, OUT_HOST_NOPC);
        trig[7] = 1'b1;
        @(posedge clk);
        #1;
        trig[7] = 1'b0;
        chk_out(outcome, OUT_GLOBAL);
        chk_flag(resetWarn, 1'b0);
        drain(1'b0);
        ackOn = 1'b1;
        for (int r = 0; r < 40; r++) begin
            {sel, fbit, dsEn, dsOk} = 4'($random(seed));
            sleep = ($random(seed) & 3) == 0 ? 2'($random(seed)) : SLP_S0;
            ackDly = 4'($random(seed));
            seq($unsigned($random(seed)) % 10);
        end
        report_and_stop();
    end

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule
